// ---- rtl/ccd_top.sv ----
// The address map and the Wishbone slave port were left to the implementer.
`timescale 1ns/1ns
// Contract
// - bits 120-123 mark post dividers A-D for power-down when one.
// - reference ratios A,B,C set0,C set1 in bits 7-0,31-24,55-48,79-72.
// - PLL B loop ratio bits 42-32, same A and M split.
// - PLL C loop ratio bits 66-56 or 90-80 by set-select pin.
// - output A ratio code bits 99-96, output B bits 103-100.
// - outputs C,D use 107-104,111-108 or 115-112,119-116 by set-select.
// - four-bit code decodes to ratios 1-6,8,9,10,12,15,16,18,20,25,50.
// - filter constant bits 20,44,68/92; zero short, one long.
// - pump current bits 19,43,67/91; zero low, one high current.
// - enabled circuit powers down only while power-down pin is high.
// - all configuration bits clear to zero at power-up.
module ccd_top (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_we_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        set_select_pin_i,
  input  wire logic        power_down_pin_i,
  input  wire logic [3:0]  mux_clk_i,
  output ccd_pkg::ccd_pll_t pll_a_o,
  output ccd_pkg::ccd_pll_t pll_b_o,
  output ccd_pkg::ccd_pll_t pll_c_o,
  output logic      [3:0]  post_off_o,
  output logic      [3:0]  clk_o
);
  logic [ccd_pkg::CFG_W-1:0] cfg;
  logic [ccd_pkg::CFG_W-1:0] next_cfg;
  logic [31:0]               next_dat;
  logic                      next_ack;
  ccd_pkg::ccd_pll_t         next_a;
  ccd_pkg::ccd_pll_t         next_b;
  ccd_pkg::ccd_pll_t         next_c;
  logic [3:0]                next_off;
  ccd_pkg::ccd_post_t [3:0]  post;
  logic [3:0]                div_clk;
  logic [3:0]                code [4];
  logic                      req;
  logic [1:0]                widx;

  // ----------------------------------------------------------------------
  // wishbone slave: four config words, status, decoded ratios
  // ----------------------------------------------------------------------
  assign req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign widx = wb_adr_i[3:2];

  always_comb begin
    next_cfg = cfg;
    next_dat = '0;
    next_ack = req;
    if (req && wb_we_i && wb_adr_i <= ccd_pkg::ADR_CFG3
        && wb_adr_i[1:0] == 2'h0) begin
      for (int b = 0; b < 4; b++) begin
        if (wb_sel_i[b]) begin
          next_cfg[widx*32 + b*8 +: 8] = wb_dat_i[b*8 +: 8];
        end
      end
    end
    if (req && !wb_we_i) begin
      if (wb_adr_i <= ccd_pkg::ADR_CFG3 && wb_adr_i[1:0] == 2'h0) begin
        next_dat = cfg[widx*32 +: 32];
      end else if (wb_adr_i == ccd_pkg::ADR_STAT) begin
        next_dat = {26'h0, set_select_pin_i, power_down_pin_i, post_off_o};
      end else if (wb_adr_i == ccd_pkg::ADR_RATIO) begin
        next_dat = {2'h0, post[3].ratio, 2'h0, post[2].ratio,
                    2'h0, post[1].ratio, 2'h0, post[0].ratio};
      end
    end
  end

  // ----------------------------------------------------------------------
  // field decode with set selection
  // ----------------------------------------------------------------------
  always_comb begin
    next_a.ref_ratio    = cfg[ccd_pkg::REF_A_LO +: 8];
    next_a.loop_a       = cfg[ccd_pkg::LOOP_A_LO +: 3];
    next_a.loop_m       = cfg[ccd_pkg::LOOP_A_LO + 3 +: 8];
    next_a.pump_current = cfg[ccd_pkg::PUMP_A_B];
    next_a.filter_tc    = cfg[ccd_pkg::TC_A_B];
    next_b.ref_ratio    = cfg[ccd_pkg::REF_B_LO +: 8];
    next_b.loop_a       = cfg[ccd_pkg::LOOP_B_LO +: 3];
    next_b.loop_m       = cfg[ccd_pkg::LOOP_B_LO + 3 +: 8];
    next_b.pump_current = cfg[ccd_pkg::PUMP_B_B];
    next_b.filter_tc    = cfg[ccd_pkg::TC_B_B];
    if (set_select_pin_i) begin
      next_c.ref_ratio    = cfg[ccd_pkg::REF_C1_LO +: 8];
      next_c.loop_a       = cfg[ccd_pkg::LOOP_C1_LO +: 3];
      next_c.loop_m       = cfg[ccd_pkg::LOOP_C1_LO + 3 +: 8];
      next_c.pump_current = cfg[ccd_pkg::PUMP_C1_B];
      next_c.filter_tc    = cfg[ccd_pkg::TC_C1_B];
      code[2] = cfg[ccd_pkg::OUT_C1_LO +: 4];
      code[3] = cfg[ccd_pkg::OUT_D1_LO +: 4];
    end else begin
      next_c.ref_ratio    = cfg[ccd_pkg::REF_C0_LO +: 8];
      next_c.loop_a       = cfg[ccd_pkg::LOOP_C0_LO +: 3];
      next_c.loop_m       = cfg[ccd_pkg::LOOP_C0_LO + 3 +: 8];
      next_c.pump_current = cfg[ccd_pkg::PUMP_C0_B];
      next_c.filter_tc    = cfg[ccd_pkg::TC_C0_B];
      code[2] = cfg[ccd_pkg::OUT_C0_LO +: 4];
      code[3] = cfg[ccd_pkg::OUT_D0_LO +: 4];
    end
    code[0] = cfg[ccd_pkg::OUT_A_LO +: 4];
    code[1] = cfg[ccd_pkg::OUT_B_LO +: 4];
    next_off = cfg[ccd_pkg::OFF_D_B:ccd_pkg::OFF_A_B]
               & {4{power_down_pin_i}};
  end

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      post[i].ratio = ccd_pkg::ccd_ratio(code[i]);
      post[i].off   = post_off_o[i];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg        <= ccd_pkg::CFG_RST;
      wb_dat_o   <= '0;
      wb_ack_o   <= 1'b0;
      pll_a_o    <= '0;
      pll_b_o    <= '0;
      pll_c_o    <= '0;
      post_off_o <= '0;
      clk_o      <= '0;
    end else begin
      cfg        <= next_cfg;
      wb_dat_o   <= next_dat;
      wb_ack_o   <= next_ack;
      pll_a_o    <= next_a;
      pll_b_o    <= next_b;
      pll_c_o    <= next_c;
      post_off_o <= next_off;
      clk_o      <= div_clk;
    end
  end

  // ----------------------------------------------------------------------
  // post dividers
  // ----------------------------------------------------------------------
  for (genvar g = 0; g < 4; g++) begin : g_post
    ccd_post_div u_div (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .src_i   (mux_clk_i[g]),
      .ratio_i (post[g].ratio),
      .off_i   (post[g].off),
      .clk_o   (div_clk[g])
    );
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  property p_off;
    @(posedge clk_i) disable iff (rst_i)
      !power_down_pin_i |=> post_off_o == 4'h0;
  endproperty
  a_off: assert property (p_off) else $error("off while pin low");

  property p_off_sel;
    @(posedge clk_i) disable iff (rst_i)
      1'b1 |=> post_off_o == ($past(cfg[123:120])
                              & {4{$past(power_down_pin_i)}});
  endproperty
  a_off_sel: assert property (p_off_sel) else $error("off bits");

  property p_loop_c;
    @(posedge clk_i) disable iff (rst_i)
      set_select_pin_i |=> pll_c_o.loop_m == $past(cfg[90:83]);
  endproperty
  a_loop_c: assert property (p_loop_c) else $error("c set1 loop");

  property p_ref_c;
    @(posedge clk_i) disable iff (rst_i)
      !set_select_pin_i |=> pll_c_o.ref_ratio == $past(cfg[55:48]);
  endproperty
  a_ref_c: assert property (p_ref_c) else $error("c set0 ref");

  property p_loop_a;
    @(posedge clk_i) disable iff (rst_i)
      1'b1 |=> pll_a_o.loop_a == $past(cfg[10:8])
               && pll_b_o.loop_m == $past(cfg[42:35]);
  endproperty
  a_loop_a: assert property (p_loop_a) else $error("a/b loop");

  property p_tune;
    @(posedge clk_i) disable iff (rst_i)
      1'b1 |=> pll_a_o.filter_tc == $past(cfg[20])
               && pll_b_o.pump_current == $past(cfg[43]);
  endproperty
  a_tune: assert property (p_tune) else $error("tuning bits");

  property p_rat;
    @(posedge clk_i) disable iff (rst_i)
      cfg[99:96] == 4'hf |-> post[0].ratio == 6'h32;
  endproperty
  a_rat: assert property (p_rat) else $error("ratio 50");

  property p_rst;
    @(posedge clk_i) rst_i |=> cfg == '0;
  endproperty
  a_rst: assert property (p_rst) else $error("cfg not cleared");

  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  property p_ack;
    @(posedge clk_i) disable iff (rst_i)
      s_req |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("ack timing");

endmodule // ccd_top

// ---- rtl/ccd_pkg.sv ----
package ccd_pkg;

  // ----------------------------------------------------------------------
  // configuration word geometry
  // ----------------------------------------------------------------------
  localparam int unsigned CFG_W      = 128;
  localparam int unsigned CFG_BYTES  = 16;
  localparam int unsigned BYTE_AW    = 4;

  // ----------------------------------------------------------------------
  // field positions (low bit of each field), loop field widths and reset value
  // ----------------------------------------------------------------------
  localparam int unsigned REF_A_LO   = 0;
  localparam int unsigned REF_B_LO   = 24;
  localparam int unsigned REF_C0_LO  = 48;
  localparam int unsigned REF_C1_LO  = 72;
  localparam int unsigned LOOP_A_LO  = 8;
  localparam int unsigned LOOP_B_LO  = 32;
  localparam int unsigned LOOP_C0_LO = 56;
  localparam int unsigned LOOP_C1_LO = 80;
  localparam int unsigned PUMP_A_B   = 19;
  localparam int unsigned PUMP_B_B   = 43;
  localparam int unsigned PUMP_C0_B  = 67;
  localparam int unsigned PUMP_C1_B  = 91;
  localparam int unsigned TC_A_B     = 20;
  localparam int unsigned TC_B_B     = 44;
  localparam int unsigned TC_C0_B    = 68;
  localparam int unsigned TC_C1_B    = 92;
  localparam int unsigned OUT_A_LO   = 96;
  localparam int unsigned OUT_B_LO   = 100;
  localparam int unsigned OUT_C0_LO  = 104;
  localparam int unsigned OUT_D0_LO  = 108;
  localparam int unsigned OUT_C1_LO  = 112;
  localparam int unsigned OUT_D1_LO  = 116;
  localparam int unsigned OFF_A_B    = 120;
  localparam int unsigned OFF_B_B    = 121;
  localparam int unsigned OFF_C_B    = 122;
  localparam int unsigned OFF_D_B    = 123;
  localparam int unsigned LOOP_A_W   = 3;
  localparam int unsigned LOOP_M_W   = 8;

  localparam logic [CFG_W-1:0] CFG_RST = '0;

  // ----------------------------------------------------------------------
  // wishbone register map (word addresses are byte offsets / 4)
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADR_CFG0   = 8'h00;
  localparam logic [7:0] ADR_CFG3   = 8'h0c;
  localparam logic [7:0] ADR_STAT   = 8'h10;
  localparam logic [7:0] ADR_RATIO  = 8'h14;

  // ----------------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] ref_ratio;
    logic [7:0] loop_m;
    logic [2:0] loop_a;
    logic       pump_current;
    logic       filter_tc;
  } ccd_pll_t;

  typedef struct packed {
    logic [5:0] ratio;
    logic       off;
  } ccd_post_t;

  // ----------------------------------------------------------------------
  // post divider modulus decode
  // ----------------------------------------------------------------------
  function automatic logic [5:0] ccd_ratio(input logic [3:0] code);
    case (code)
      4'h0: ccd_ratio = 6'h01;
      4'h1: ccd_ratio = 6'h02;
      4'h2: ccd_ratio = 6'h03;
      4'h3: ccd_ratio = 6'h04;
      4'h4: ccd_ratio = 6'h05;
      4'h5: ccd_ratio = 6'h06;
      4'h6: ccd_ratio = 6'h08;
      4'h7: ccd_ratio = 6'h09;
      4'h8: ccd_ratio = 6'h0a;
      4'h9: ccd_ratio = 6'h0c;
      4'ha: ccd_ratio = 6'h0f;
      4'hb: ccd_ratio = 6'h10;
      4'hc: ccd_ratio = 6'h12;
      4'hd: ccd_ratio = 6'h14;
      4'he: ccd_ratio = 6'h19;
      default: ccd_ratio = 6'h32;
    endcase
  endfunction

endpackage

// ---- rtl/ccd_post_div.sv ----
`timescale 1ns/1ns
module ccd_post_div (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       src_i,
  input  wire logic [5:0] ratio_i,
  input  wire logic       off_i,
  output logic            clk_o
);
  logic [5:0] cnt;
  logic [5:0] next_cnt;
  logic       out;
  logic       next_out;
  logic       src_q;
  logic       rise;

  // ----------------------------------------------------------------------
  // period counter on source rising edges
  // ----------------------------------------------------------------------
  assign rise = src_i & ~src_q;

  always_comb begin
    next_cnt = cnt;
    next_out = out;
    if (off_i) begin
      next_cnt = '0;
      next_out = 1'b0;
    end else if (ratio_i == 6'h01) begin
      next_cnt = '0;
      next_out = src_i;
    end else if (rise) begin
      if (cnt >= ratio_i - 6'h01) begin
        next_cnt = '0;
      end else begin
        next_cnt = cnt + 6'h01;
      end
      next_out = (next_cnt < (ratio_i >> 1));
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt   <= '0;
      out   <= 1'b0;
      src_q <= 1'b0;
    end else begin
      cnt   <= next_cnt;
      out   <= next_out;
      src_q <= src_i;
    end
  end

  assign clk_o = out;

endmodule // ccd_post_div

// ---- tb/ccd_top_test.sv ----
`timescale 1ns/1ns
module ccd_top_test;
  logic              clk_i    = 1'b0;
  logic              rst_i    = 1'b1;
  logic [7:0]        wb_adr_i = 8'h00;
  logic [31:0]       wb_dat_i = 32'h0;
  logic [3:0]        wb_sel_i = 4'h0;
  logic              wb_we_i  = 1'b0;
  logic              wb_cyc_i = 1'b0;
  logic              wb_stb_i = 1'b0;
  logic [31:0]       wb_dat_o;
  logic              wb_ack_o;
  logic              sel_pin  = 1'b0;
  logic              pd_pin   = 1'b0;
  logic [3:0]        src_cnt  = 4'h0;
  ccd_pkg::ccd_pll_t pll_a;
  ccd_pkg::ccd_pll_t pll_b;
  ccd_pkg::ccd_pll_t pll_c;
  logic [3:0]        post_off;
  logic [3:0]        clk_div;
  logic [127:0]      cfg;
  logic [31:0]       q;
  int                mismatches = 0;
  int                n_checks   = 0;
  logic [5:0]        rt [16] = '{6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06,
    6'h08, 6'h09, 6'h0a, 6'h0c, 6'h0f, 6'h10, 6'h12, 6'h14, 6'h19, 6'h32};

  ccd_top u_ccd_top (
    .clk_i            (clk_i),
    .rst_i            (rst_i),
    .wb_adr_i         (wb_adr_i),
    .wb_dat_i         (wb_dat_i),
    .wb_sel_i         (wb_sel_i),
    .wb_we_i          (wb_we_i),
    .wb_cyc_i         (wb_cyc_i),
    .wb_stb_i         (wb_stb_i),
    .wb_dat_o         (wb_dat_o),
    .wb_ack_o         (wb_ack_o),
    .set_select_pin_i (sel_pin),
    .power_down_pin_i (pd_pin),
    .mux_clk_i        ({4{src_cnt[1]}}),
    .pll_a_o          (pll_a),
    .pll_b_o          (pll_b),
    .pll_c_o          (pll_c),
    .post_off_o       (post_off),
    .clk_o            (clk_div)
  );

  initial forever #2 clk_i = ~clk_i;
  always @(posedge clk_i) src_cnt <= src_cnt + 4'h1;

  // ----------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------
  task automatic chk(input string what, input logic [127:0] seen,
                     input logic [127:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic wb_cycle(input logic [7:0] adr, input logic we,
                          input logic [3:0] sel, input logic [31:0] d);
    int i;
    @(posedge clk_i);
    wb_adr_i <= adr;
    wb_we_i  <= we;
    wb_sel_i <= sel;
    wb_dat_i <= d;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk_i);
      if (wb_ack_o === 1'b1) break;
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    if (i == 20) begin
      mismatches++;
      final_report;
    end
  endtask

  task automatic wr(input logic [7:0] adr, input logic [31:0] d);
    wb_cycle(adr, 1'b1, 4'hf, d);
  endtask

  task automatic rd(input logic [7:0] adr);
    wb_cycle(adr, 1'b0, 4'hf, 32'h0);
  endtask

  task automatic settle;
    repeat (3) @(posedge clk_i);
  endtask

  function automatic ccd_pkg::ccd_pll_t exp_pll(input int r, input int l,
                                                input int p, input int t);
    exp_pll.ref_ratio    = cfg[r+:8];
    exp_pll.loop_m       = cfg[l+3+:8];
    exp_pll.loop_a       = cfg[l+:3];
    exp_pll.pump_current = cfg[p];
    exp_pll.filter_tc    = cfg[t];
  endfunction

  task automatic count_rises(input int b, output int n);
    logic p;
    p = clk_div[b];
    n = 0;
    repeat (64) begin
      @(posedge clk_i);
      if (clk_div[b] === 1'b1 && p === 1'b0) n++;
      p = clk_div[b];
    end
  endtask

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset;
    sel_pin <= 1'b0;
    pd_pin  <= 1'b0;
    rst_i   <= 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    cfg = '0;
    for (int n = 0; n < 4; n++) begin
      rd(8'(4 * n));
      chk("cfg word", q, 128'h0);
    end
    chk("pll a", pll_a, 128'h0);
    chk("pll c", pll_c, 128'h0);
    chk("post off", post_off, 128'h0);
    $display("test reset done");
  endtask

  task automatic t_pll;
    cfg = {32'h0, 32'h8bd73c52, 32'he1f2a5c3, 32'h4b6b96d1};
    for (int n = 0; n < 4; n++) wr(8'(4 * n), cfg[32*n+:32]);
    settle;
    chk("pll a", pll_a, exp_pll(0, 8, 19, 20));
    chk("pll b", pll_b, exp_pll(24, 32, 43, 44));
    sel_pin <= 1'b1;
    settle;
    chk("pll c set1", pll_c, exp_pll(72, 80, 91, 92));
    sel_pin <= 1'b0;
    settle;
    chk("pll c set0", pll_c, exp_pll(48, 56, 67, 68));
    wb_cycle(8'h04, 1'b1, 4'h4, 32'h11771111);
    cfg[48+:8] = 8'h77;
    rd(8'h04);
    chk("lane write", q, cfg[32+:32]);
    wr(8'h20, 32'hffffffff);
    rd(8'h20);
    chk("unmapped read", q, 128'h0);
    rd(8'h0c);
    chk("word3 kept", q, cfg[96+:32]);
    $display("test pll done");
  endtask

  task automatic t_post;
    logic [3:0]  v;
    logic [31:0] e;
    wr(8'h0c, 32'h0f000000);
    pd_pin <= 1'b1;
    settle;
    for (int k = 0; k < 16; k++) begin
      v = 4'(k);
      wr(8'h0c, {8'h0f, v + 4'h4, v + 4'h3, v + 4'h2, v + 4'h1, ~v, v});
      for (int s = 0; s < 2; s++) begin
        sel_pin <= s[0];
        settle;
        rd(8'h14);
        e = {2'b0, rt[s ? v + 4'h4 : v + 4'h2], 2'b0,
             rt[s ? v + 4'h3 : v + 4'h1], 2'b0, rt[~v], 2'b0, rt[v]};
        chk("ratios", q, e);
      end
    end
    sel_pin <= 1'b0;
    $display("test post done");
  endtask

  task automatic t_power;
    int n;
    wr(8'h0c, 32'h0c000010);
    pd_pin <= 1'b0;
    settle;
    chk("off pin low", post_off, 128'h0);
    pd_pin <= 1'b1;
    settle;
    chk("off pin high", post_off, 128'hc);
    rd(8'h10);
    chk("status", q, 128'h1c);
    count_rises(0, n);
    chk("ratio one", n >= 15 && n <= 17, 128'h1);
    count_rises(1, n);
    chk("ratio two", n >= 7 && n <= 9, 128'h1);
    count_rises(3, n);
    chk("d stopped", n, 128'h0);
    count_rises(2, n);
    chk("c stopped", n, 128'h0);
    pd_pin <= 1'b0;
    settle;
    count_rises(3, n);
    chk("d running", n >= 15 && n <= 17, 128'h1);
    $display("test power done");
  endtask

  initial begin
    t_reset;
    t_pll;
    t_post;
    t_power;
    t_reset;
    final_report;
  end
endmodule // ccd_top_test
